// file: verilog/misx_pkg.sv
package misx_pkg;
  localparam int MISX_W = 16;
  // ------------------------------------------------------------
  // opcode patterns
  // ------------------------------------------------------------
  localparam logic [15:0] MISX_OP_STOP = 16'h0000;
  localparam logic [15:0] MISX_OP_BKPT = 16'h0003;
  localparam logic [7:0] MISX_HI_JMP = 8'h01;
  localparam logic [7:0] MISX_HI_JNV = 8'h84;
  localparam logic [7:0] MISX_HI_JV = 8'h85;
  localparam logic [7:0] MISX_HI_EMT = 8'h88;
  localparam logic [10:0] MISX_CC_PAT = 11'h005;
  localparam logic [9:0] MISX_ZF_PAT = 10'h028;
  localparam logic [9:0] MISX_INV_PAT = 10'h029;
  localparam logic [9:0] MISX_DEC_PAT = 10'h02B;
  localparam logic [3:0] MISX_CMP_PAT = 4'h2;
  localparam logic [6:0] MISX_DIV_PAT = 7'h39;
  localparam int MISX_CC_SENSE = 4;
  localparam int MISX_DIV_PAIR = 1;
  // ------------------------------------------------------------
  // trap vectors and status bits
  // ------------------------------------------------------------
  localparam logic [15:0] MISX_VEC_BKPT = 16'h000C;
  localparam logic [15:0] MISX_VEC_EMT = 16'h0018;
  localparam logic [15:0] MISX_VEC_USR_STOP = 16'h0008;
  localparam logic [15:0] MISX_VEC_STEP = 16'h0002;
  localparam logic [15:0] MISX_MIN_NEG = 16'h8000;
  localparam logic [15:0] MISX_ZERO = 16'h0000;
  localparam logic [15:0] MISX_ONE = 16'h0001;
  localparam logic [3:0] MISX_CC_CLR_ZF = 4'h4;
  localparam int MISX_FN = 3;
  localparam int MISX_FZ = 2;
  localparam int MISX_FV = 1;
  localparam int MISX_FC = 0;
  typedef enum logic [2:0] {
    MISX_T_NONE,
    MISX_T_PUSH_PS,
    MISX_T_PUSH_PC,
    MISX_T_LOAD_PC,
    MISX_T_LOAD_PS
  } misx_trap_e;
endpackage

// file: verilog/misx_div.sv
`timescale 1ns/1ns
module misx_div
  import misx_pkg::*;
(
  input wire logic [31:0] i_dividend,
  input wire logic [15:0] i_divisor,
  output logic [15:0] o_quot,
  output logic [15:0] o_rem,
  output logic o_abort,
  output logic o_by_zero
);
  // ------------------------------------------------------------
  // signed divide, remainder follows dividend sign
  // ------------------------------------------------------------
  logic [31:0] mag_n;
  logic [31:0] mag_d;
  logic [31:0] q_mag;
  logic [31:0] r_mag;
  logic q_neg;
  always_comb begin
    mag_n = i_dividend[31] ? (~i_dividend + 32'h00000001) : i_dividend;
    mag_d = i_divisor[15] ? {16'h0000, (~i_divisor + MISX_ONE)} : {16'h0000, i_divisor};
    o_by_zero = (i_divisor == MISX_ZERO);
    q_neg = i_dividend[31] ^ i_divisor[15];
    q_mag = o_by_zero ? 32'h00000000 : (mag_n / mag_d);
    r_mag = o_by_zero ? 32'h00000000 : (mag_n % mag_d);
    o_abort = o_by_zero || (q_neg ? (q_mag > 32'h00008000) : (q_mag > 32'h00007FFF));
    o_quot = q_neg ? (~q_mag[15:0] + MISX_ONE) : q_mag[15:0];
    o_rem = i_dividend[31] ? (~r_mag[15:0] + MISX_ONE) : r_mag[15:0];
  end
endmodule

// file: verilog/misx_exec.sv
`timescale 1ns/1ns
// Function
// - always jump adds twice offset
// - jump when overflow flag clear
// - jump when overflow flag set
// - bit 4 sets/clears flags in bits 0-3
// - zero fill writes zero, sets Z only
// - zero fill final access is plain write
// - compare src plus inverted dst plus one
// - compare overflow from operand/result signs
// - compare carry is inverted carry out
// - invert complements dst, sets carry
// - decrement, overflow on 100000 octal
// - divide even register pair by source
// - divide aborts on zero or overflow
// - emulator trap range vectors through 30
// - stop in kernel, trap 10 in user
module misx_exec
  import misx_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic [15:0] i_instr,
  input wire logic [15:0] i_src,
  input wire logic [15:0] i_dst,
  input wire logic [15:0] i_reg_odd,
  input wire logic [15:0] i_pc,
  input wire logic [15:0] i_ps,
  input wire logic i_user_mode,
  output logic o_done,
  output logic [15:0] o_pc,
  output logic [3:0] o_flags,
  output logic o_flags_we,
  output logic [15:0] o_result,
  output logic o_result_we,
  output logic [15:0] o_result2,
  output logic o_result2_we,
  output logic o_rmw,
  output logic o_halt,
  output logic o_push,
  output logic [15:0] o_push_data,
  output logic o_vec_read,
  output logic [15:0] o_vec_addr,
  output logic o_illegal
);
  misx_trap_e trap;
  misx_trap_e next_trap;
  logic [15:0] vec;
  logic [15:0] next_vec;
  logic [15:0] save_ps;
  logic [15:0] next_save_ps;
  logic next_done;
  logic [15:0] next_pc;
  logic [3:0] next_flags;
  logic next_flags_we;
  logic [15:0] next_result;
  logic next_result_we;
  logic [15:0] next_result2;
  logic next_result2_we;
  logic next_rmw;
  logic next_halt;
  logic next_push;
  logic [15:0] next_push_data;
  logic next_vec_read;
  logic [15:0] next_vec_addr;
  logic next_illegal;
  logic [15:0] div_q;
  logic [15:0] div_r;
  logic div_abort;
  logic div_zero;
  logic [16:0] cmp_sum;
  logic [15:0] br_off;
  logic [15:0] r;
  logic [3:0] f;
  logic [3:0] ccn;

  misx_div u_div (
    .i_dividend({i_dst, i_reg_odd}),
    .i_divisor(i_src),
    .o_quot(div_q),
    .o_rem(div_r),
    .o_abort(div_abort),
    .o_by_zero(div_zero)
  );

  // ------------------------------------------------------------
  // decode and execute
  // ------------------------------------------------------------
  always_comb begin
    next_trap = trap;
    next_vec = vec;
    next_save_ps = save_ps;
    next_done = 1'b0;
    next_pc = o_pc;
    next_flags = o_flags;
    next_flags_we = 1'b0;
    next_result = o_result;
    next_result_we = 1'b0;
    next_result2 = o_result2;
    next_result2_we = 1'b0;
    next_rmw = 1'b0;
    next_halt = o_halt;
    next_push = 1'b0;
    next_push_data = o_push_data;
    next_vec_read = 1'b0;
    next_vec_addr = o_vec_addr;
    next_illegal = 1'b0;
    f = i_ps[3:0];
    r = MISX_ZERO;
    ccn = MISX_CC_CLR_ZF;
    br_off = {{7{i_instr[7]}}, i_instr[7:0], 1'b0};
    cmp_sum = {1'b0, i_src} + {1'b0, ~i_dst} + {16'h0000, 1'b1};
    unique case (trap)
      MISX_T_NONE: begin
        if (i_start) begin
          if (i_instr[15:8] == MISX_HI_JMP) begin
            next_pc = i_pc + br_off;
            next_done = 1'b1;
          end else if (i_instr[15:8] == MISX_HI_JNV) begin
            next_pc = f[MISX_FV] ? i_pc : i_pc + br_off;
            next_done = 1'b1;
          end else if (i_instr[15:8] == MISX_HI_JV) begin
            next_pc = f[MISX_FV] ? i_pc + br_off : i_pc;
            next_done = 1'b1;
          end else if (i_instr[15:5] == MISX_CC_PAT) begin
            next_flags = i_instr[MISX_CC_SENSE] ? (f | i_instr[3:0]) : (f & ~i_instr[3:0]);
            next_flags_we = 1'b1;
            next_done = 1'b1;
          end else if (i_instr[14:6] == MISX_ZF_PAT[8:0]) begin
            next_result = MISX_ZERO;
            next_result_we = 1'b1;
            next_rmw = 1'b0;
            next_flags = ccn;
            next_flags_we = 1'b1;
            next_done = 1'b1;
          end else if (i_instr[14:12] == MISX_CMP_PAT[2:0]) begin
            r = cmp_sum[15:0];
            next_flags[MISX_FN] = r[15];
            next_flags[MISX_FZ] = (r == MISX_ZERO);
            next_flags[MISX_FV] = (i_src[15] != i_dst[15]) && (i_dst[15] == r[15]);
            next_flags[MISX_FC] = ~cmp_sum[16];
            next_flags_we = 1'b1;
            next_done = 1'b1;
          end else if (i_instr[14:6] == MISX_INV_PAT[8:0]) begin
            r = ~i_dst;
            next_result = r;
            next_result_we = 1'b1;
            next_rmw = 1'b1;
            next_flags = {r[15], (r == MISX_ZERO), 1'b0, 1'b1};
            next_flags_we = 1'b1;
            next_done = 1'b1;
          end else if (i_instr[14:6] == MISX_DEC_PAT[8:0]) begin
            r = i_dst - MISX_ONE;
            next_result = r;
            next_result_we = 1'b1;
            next_rmw = 1'b1;
            next_flags = {r[15], (r == MISX_ZERO), (i_dst == MISX_MIN_NEG), f[MISX_FC]};
            next_flags_we = 1'b1;
            next_done = 1'b1;
          end else if (i_instr[15:9] == MISX_DIV_PAT) begin
            if (i_instr[6] == MISX_DIV_PAIR[0]) begin
              next_illegal = 1'b1;
            end else if (div_abort) begin
              next_flags = {f[MISX_FN], f[MISX_FZ], 1'b1, div_zero};
              next_flags_we = 1'b1;
            end else begin
              next_result = div_q;
              next_result_we = 1'b1;
              next_result2 = div_r;
              next_result2_we = 1'b1;
              next_flags = {div_q[15], (div_q == MISX_ZERO), 1'b0, 1'b0};
              next_flags_we = 1'b1;
            end
            next_done = 1'b1;
          end else if (i_instr[15:8] == MISX_HI_EMT) begin
            next_vec = MISX_VEC_EMT;
            next_save_ps = i_ps;
            next_trap = MISX_T_PUSH_PS;
          end else if (i_instr == MISX_OP_BKPT) begin
            next_vec = MISX_VEC_BKPT;
            next_save_ps = i_ps;
            next_trap = MISX_T_PUSH_PS;
          end else if (i_instr == MISX_OP_STOP) begin
            if (i_user_mode) begin
              next_vec = MISX_VEC_USR_STOP;
              next_save_ps = i_ps;
              next_trap = MISX_T_PUSH_PS;
            end else begin
              next_halt = 1'b1;
              next_done = 1'b1;
            end
          end else begin
            next_illegal = 1'b1;
            next_done = 1'b1;
          end
        end
      end
      MISX_T_PUSH_PS: begin
        next_push = 1'b1;
        next_push_data = save_ps;
        next_trap = MISX_T_PUSH_PC;
      end
      MISX_T_PUSH_PC: begin
        next_push = 1'b1;
        next_push_data = i_pc;
        next_trap = MISX_T_LOAD_PC;
      end
      MISX_T_LOAD_PC: begin
        next_vec_read = 1'b1;
        next_vec_addr = vec;
        next_trap = MISX_T_LOAD_PS;
      end
      MISX_T_LOAD_PS: begin
        next_vec_read = 1'b1;
        next_vec_addr = vec + MISX_VEC_STEP;
        next_trap = MISX_T_NONE;
        next_done = 1'b1;
      end
      default: begin
        next_trap = MISX_T_NONE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      trap <= MISX_T_NONE;
      vec <= MISX_ZERO;
      save_ps <= MISX_ZERO;
      o_done <= 1'b0;
      o_pc <= MISX_ZERO;
      o_flags <= 4'h0;
      o_flags_we <= 1'b0;
      o_result <= MISX_ZERO;
      o_result_we <= 1'b0;
      o_result2 <= MISX_ZERO;
      o_result2_we <= 1'b0;
      o_rmw <= 1'b0;
      o_halt <= 1'b0;
      o_push <= 1'b0;
      o_push_data <= MISX_ZERO;
      o_vec_read <= 1'b0;
      o_vec_addr <= MISX_ZERO;
      o_illegal <= 1'b0;
    end else begin
      trap <= next_trap;
      vec <= next_vec;
      save_ps <= next_save_ps;
      o_done <= next_done;
      o_pc <= next_pc;
      o_flags <= next_flags;
      o_flags_we <= next_flags_we;
      o_result <= next_result;
      o_result_we <= next_result_we;
      o_result2 <= next_result2;
      o_result2_we <= next_result2_we;
      o_rmw <= next_rmw;
      o_halt <= next_halt;
      o_push <= next_push;
      o_push_data <= next_push_data;
      o_vec_read <= next_vec_read;
      o_vec_addr <= next_vec_addr;
      o_illegal <= next_illegal;
    end
  end
endmodule

// file: sim/misx_exec_sva.sv
`timescale 1ns/1ns
module misx_exec_chk
  import misx_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic [15:0] i_instr,
  input wire logic [15:0] i_src,
  input wire logic [15:0] i_dst,
  input wire logic [15:0] i_pc,
  input wire logic [15:0] i_ps,
  input wire logic i_user_mode,
  input wire logic o_done,
  input wire logic [15:0] o_pc,
  input wire logic [3:0] o_flags,
  input wire logic o_flags_we,
  input wire logic [15:0] o_result,
  input wire logic o_result_we,
  input wire logic o_rmw,
  input wire logic o_halt,
  input wire logic o_push,
  input wire logic [15:0] o_push_data,
  input wire logic o_vec_read,
  input wire logic [15:0] o_vec_addr
);
  // ------------------------------------------------------------
  // trap tracking and checks
  // ------------------------------------------------------------
  logic [2:0] tcnt;
  logic [2:0] next_tcnt;
  logic take;
  logic [15:0] tgt;
  always_comb begin
    take = i_start && (tcnt == 3'h0);
    tgt = i_pc + {{7{i_instr[7]}}, i_instr[7:0], 1'b0};
    next_tcnt = tcnt - {2'h0, tcnt != 3'h0};
    if (take && (i_instr[15:8] == MISX_HI_EMT || i_instr == MISX_OP_BKPT
        || (i_instr == MISX_OP_STOP && i_user_mode))) begin
      next_tcnt = 3'h4;
    end
  end
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tcnt <= 3'h0;
    end else begin
      tcnt <= next_tcnt;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  jump_target_a: assert property (take && i_instr[15:8] == MISX_HI_JMP |=>
    o_done && o_pc == $past(tgt) && !o_flags_we) else $error("jump target wrong");
  jump_nv_a: assert property (take && i_instr[15:8] == MISX_HI_JNV |=>
    o_pc == ($past(i_ps[1]) ? $past(i_pc) : $past(tgt))) else $error("no-ovf jump wrong");
  jump_v_a: assert property (take && i_instr[15:8] == MISX_HI_JV |=>
    o_pc == ($past(i_ps[1]) ? $past(tgt) : $past(i_pc))) else $error("ovf jump wrong");
  cc_flags_a: assert property (take && i_instr[15:5] == MISX_CC_PAT |=> o_flags_we &&
    o_flags == ($past(i_instr[4]) ? $past(i_ps[3:0] | i_instr[3:0])
    : $past(i_ps[3:0] & ~i_instr[3:0]))) else $error("cc op flags wrong");
  zero_fill_a: assert property (take && i_instr[14:6] == MISX_ZF_PAT[8:0] |=>
    o_result_we && o_result == 16'h0000 && !o_rmw && o_flags == 4'h4)
    else $error("zero fill wrong");
  invert_flags_a: assert property (take && i_instr[14:6] == MISX_INV_PAT[8:0] |=>
    o_result == ~$past(i_dst) && o_flags[1:0] == 2'b01) else $error("invert wrong");
  dec_overflow_a: assert property (take && i_instr[14:6] == MISX_DEC_PAT[8:0] |=>
    o_flags[1] == ($past(i_dst) == MISX_MIN_NEG) && o_flags[0] == $past(i_ps[0]))
    else $error("decrement flags wrong");
  emt_sequence_a: assert property (take && i_instr[15:8] == MISX_HI_EMT |=> ##1
    o_push && o_push_data == $past(i_ps, 2) ##1 o_push && o_push_data == $past(i_pc)
    ##1 o_vec_read && o_vec_addr == 16'h0018
    ##1 o_vec_read && o_done && o_vec_addr == 16'h001A) else $error("emulator trap wrong");
  div_zero_a: assert property (take && i_instr[15:9] == MISX_DIV_PAT && !i_instr[6]
    && i_src == 16'h0000 |=> o_flags[1:0] == 2'b11 && !o_result_we) else $error("div0 wrong");
  kernel_stop_a: assert property (take && i_instr == MISX_OP_STOP && !i_user_mode |=>
    o_halt && o_done && !o_push) else $error("kernel stop wrong");
endmodule

// file: sim/test_minicomputer_isa_exec_slice.sv
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module test_minicomputer_isa_exec_slice;
  import misx_pkg::*;
  // ------------------------------------------------------------
  // stimulus and checks
  // ------------------------------------------------------------
  logic i_core_clk, i_reset_n, i_start, i_user_mode;
  logic [15:0] i_instr, i_src, i_dst, i_reg_odd, i_pc, i_ps;
  logic o_done, o_flags_we, o_result_we, o_result2_we, o_rmw, o_halt, o_push, o_vec_read;
  logic o_illegal;
  logic [15:0] o_pc, o_result, o_result2, o_push_data, o_vec_addr;
  logic [3:0] o_flags;
  logic [16:0] r;
  int n_mismatch, n_tests, cyc;
  misx_exec i_dut (.*);
  task automatic go(input logic [15:0] in, s, d, od, p);
    @(posedge i_core_clk);
    i_start <= 1'b1;
    i_instr <= in;
    i_src <= s;
    i_dst <= d;
    i_reg_odd <= od;
    i_ps <= p;
    @(posedge i_core_clk);
    i_start <= 1'b0;
    #1;
  endtask
  task automatic op(input logic [15:0] in, d, p, res, input logic [3:0] f, input logic rmw);
    go(in, 16'h0000, d, 16'h0000, p);
    `CHK({o_result_we, o_result, o_flags, o_rmw, o_done}, {1'b1, res, f, rmw, 1'b1})
  endtask
  task automatic t_branch();
    go(16'h017F, 0, 0, 0, 0);
    `CHK({o_pc, o_flags_we, o_done}, 18'h043F9)
    go(16'h0180, 0, 0, 0, 0);
    `CHK(o_pc, 16'h0F00)
    go(16'h8410, 0, 0, 0, 16'h0002);
    `CHK(o_pc, 16'h1000)
    go(16'h8410, 0, 0, 0, 0);
    `CHK(o_pc, 16'h1020)
    go(16'h85F0, 0, 0, 0, 0);
    `CHK(o_pc, 16'h1000)
    go(16'h85F0, 0, 0, 0, 16'h0002);
    `CHK(o_pc, 16'h0FE0)
  endtask
  task automatic t_cc();
    for (int m = 0; m < 32; m++) begin
      go(16'h00A0 | 16'(m), 0, 0, 0, 16'h000A);
      `CHK(o_flags, m[4] ? (4'hA | 4'(m)) : (4'hA & ~4'(m)))
    end
  endtask
  task automatic t_cmp(input logic [15:0] s, d);
    r = {1'b0, s} + {1'b0, ~d} + 17'h00001;
    go(16'h2042, s, d, 0, 0);
    `CHK({o_result_we, o_flags_we, o_done}, 3'h3)
    `CHK(o_flags[3:2], {r[15], r[15:0] == 16'h0000})
    `CHK(o_flags[1], s[15] != d[15] && d[15] == r[15])
    `CHK(o_flags[0], !r[16])
  endtask
  task automatic t_div();
    go(16'h7201, 16'h0002, 16'hFFFF, 16'hFFF9, 0);
    `CHK({o_result, o_result2, o_flags}, 36'hFFFDFFFF8)
    `CHK({o_result_we, o_result2_we}, 2'b11)
    go(16'h7201, 0, 16'h0001, 0, 16'h000C);
    `CHK({o_flags, o_result_we}, 5'h1E)
    go(16'h7201, 16'h0001, 16'h0001, 0, 0);
    `CHK({o_flags, o_result_we}, 5'h04)
    go(16'h7241, 16'h0001, 0, 0, 0);
    `CHK(o_illegal, 1'b1)
  endtask
  task automatic t_trap(input logic [15:0] in, vec, input logic um);
    @(posedge i_core_clk);
    i_user_mode <= um;
    go(in, 0, 0, 0, 16'h00E5);
    `CHK({o_push, o_done}, 2'b00)
    @(posedge i_core_clk) #1;
    `CHK({o_push, o_push_data}, 17'h100E5)
    @(posedge i_core_clk) #1;
    `CHK({o_push, o_push_data}, 17'h11000)
    @(posedge i_core_clk) #1;
    `CHK({o_vec_read, o_vec_addr}, {1'b1, vec})
    @(posedge i_core_clk) #1;
    `CHK({o_vec_read, o_vec_addr, o_done}, {1'b1, vec + 16'h0002, 1'b1})
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    {i_reset_n, i_start, i_user_mode, i_instr, i_src, i_dst, i_reg_odd, i_ps} = '0;
    i_pc = 16'h1000;
    repeat (20) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    t_branch();
    t_cc();
    op(16'h0A00, 16'h1234, 16'h000B, 16'h0000, 4'h4, 1'b0);
    op(16'h0A40, 16'h00FF, 16'h0000, 16'hFF00, 4'h9, 1'b1);
    op(16'h0A40, 16'hFFFF, 16'h0000, 16'h0000, 4'h5, 1'b1);
    op(16'h0AC0, 16'h8000, 16'h0001, 16'h7FFF, 4'h3, 1'b1);
    op(16'h0AC0, 16'h0001, 16'h0000, 16'h0000, 4'h4, 1'b1);
    t_cmp(16'h8000, 16'h0001);
    t_cmp(16'h0005, 16'h0005);
    t_cmp(16'h0001, 16'h0002);
    t_cmp(16'h7FFF, 16'hFFFF);
    t_div();
    t_trap(16'h88FF, 16'h0018, 1'b0);
    t_trap(16'h8800, 16'h0018, 1'b0);
    t_trap(16'h0003, 16'h000C, 1'b0);
    t_trap(16'h0000, 16'h0008, 1'b1);
    @(posedge i_core_clk);
    i_user_mode <= 1'b0;
    go(16'h0000, 0, 0, 0, 0);
    `CHK({o_halt, o_done, o_push}, 3'b110)
    tally_and_finish();
  end
endmodule
bind misx_exec misx_exec_chk u_chk (.*);
